// ---- spr_pkg.sv ----
// Constants and types shared by the PHY register space design
package spr_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int LONG_RESET_NS = 166000;
  localparam int SHORT_RESET_NS = 1300;
  localparam int LONG_RESET_CYC =
    (LONG_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_RESET_CYC =
    (SHORT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 12;

  // ************************************************************
  // Register indices, byte address is four times the index
  // ************************************************************
  localparam logic [3:0] IDX_NODE = 4'h0;
  localparam logic [3:0] IDX_RESET = 4'h1;
  localparam logic [3:0] IDX_PORTCAP = 4'h2;
  localparam logic [3:0] IDX_SPEED = 4'h3;
  localparam logic [3:0] IDX_SELFID = 4'h4;
  localparam logic [3:0] IDX_EVENT = 4'h5;
  localparam logic [3:0] IDX_RSVD6 = 4'h6;
  localparam logic [3:0] IDX_SELECT = 4'h7;
  localparam logic [3:0] IDX_PORT_CTRL = 4'h9;
  localparam logic [2:0] PAGE_PORT = 3'h0;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int B_HOLDOFF = 7;
  localparam int B_LONGREQ = 6;
  localparam int B_LINK_ACTIVE_CONTROL = 7;
  localparam int B_CONTEND = 6;
  localparam int B_WDOG = 7;
  localparam int B_SHORTREQ = 6;
  localparam int B_FLAG_LO = 2;
  localparam int B_ACCEL = 1;
  localparam int B_MULTI = 0;
  localparam int B_INTEN = 4;
  localparam int FLG_PEVT = 0;
  localparam int FLG_TOUT = 1;
  localparam int FLG_PFAIL = 2;
  localparam int FLG_LOOP = 3;
  localparam int NUM_FLAGS = 4;
  localparam int NUM_PORTS = 2;

  // ************************************************************
  // Fixed fields and reset values
  // ************************************************************
  localparam logic [2:0] EXT_CODE = 3'h7;
  localparam logic [3:0] TOTAL_PORTS = 4'h2;
  localparam logic [2:0] MAX_SPEED = 3'h2;
  localparam logic [3:0] DELAY_CODE = 4'h0;
  localparam logic [2:0] JITTER_CODE = 3'h0;
  localparam logic [5:0] GAP_RESET = 6'h3f;
  localparam logic [2:0] PAGE_RESET = 3'h0;
  localparam logic [3:0] PORT_RESET = 4'h0;
  localparam logic LINK_ACTIVE_CONTROL_RESET = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } spr_rst_state_type;

endpackage

// ---- spr_flag_if.sv ----
// Set, clear and state of one sticky event flag
`timescale 1ns/1ps
interface spr_flag_if;
  logic set;
  logic clear;
  logic flag;
  modport owner (input set, input clear, output flag);
  modport user (output set, output clear, input flag);
endinterface

// ---- spr_event_flag.sv ----
// Sticky event flag, hardware set wins over software clear
`timescale 1ns/1ps
module spr_event_flag
  import spr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  spr_flag_if.owner fl
);

  logic flag_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_reg <= 1'b0;
    end else if (fl.set) begin
      flag_reg <= 1'b1;
    end else if (fl.clear) begin
      flag_reg <= 1'b0;
    end
  end

  assign fl.flag = flag_reg;

  a_flag_set_wins: assert property (@(posedge clk) disable iff (!nrst)
    fl.set |=> fl.flag) else $error("flag set lost");
  a_flag_clear: assert property (@(posedge clk) disable iff (!nrst)
    fl.clear && !fl.set |=> !fl.flag) else $error("flag not cleared");

endmodule // spr_event_flag

// ---- spr_reset_timer.sv ----
// Bus reset launcher and duration timer
`timescale 1ns/1ps
module spr_reset_timer
  import spr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic reqLong,
  input wire logic reqShort,
  input wire logic stateTimeout,
  input wire logic phyBusy,
  output logic resetBegin,
  output logic resetActive,
  output logic resetLong
);

  spr_rst_state_type state_reg;
  logic [RST_CNT_W-1:0] count_reg;
  logic isLong_reg;
  logic begin_reg;
  logic launch;
  logic launchLong;

  // Long wins; in idle a state time-out forces a long reset at once, even when busy
  always_comb begin
    launchLong = reqLong | stateTimeout;
    launch = 1'b0;
    if (state_reg == ST_IDLE) begin
      launch = stateTimeout | ((reqLong | reqShort) & ~phyBusy);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      count_reg <= '0;
      isLong_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (launch) begin
            state_reg <= ST_RUN;
            isLong_reg <= launchLong;
            count_reg <= launchLong ? RST_CNT_W'(LONG_RESET_CYC - 1) :
              RST_CNT_W'(SHORT_RESET_CYC - 1);
          end
        end
        ST_RUN: begin
          if (count_reg == '0) begin
            state_reg <= ST_IDLE;
          end else begin
            count_reg <= count_reg - 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      begin_reg <= 1'b0;
    end else begin
      begin_reg <= launch;
    end
  end

  assign resetBegin = begin_reg;
  assign resetActive = (state_reg == ST_RUN);
  assign resetLong = isLong_reg;

  a_short_length: assert property (@(posedge clk) disable iff (!nrst)
    launch && !launchLong |-> ##26 resetActive ##1 !resetActive)
    else $error("short reset length wrong");
  a_wait_busy: assert property (@(posedge clk) disable iff (!nrst)
    phyBusy && !stateTimeout && !resetActive |=> !resetActive)
    else $error("reset started while busy");

endmodule // spr_reset_timer

// ---- spr_phy_regs.sv ----
// Register space of a two-port cable PHY on a Wishbone slave
`timescale 1ns/1ps
module spr_phy_regs
  import spr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic cablePowerIn,
  input wire logic linkPowerStatus,
  input wire logic [2:0] powerCategoryStraps,
  input wire logic phyBusy,
  input wire logic peerBusReset,
  input wire logic selfIdDone,
  input wire logic [5:0] selfIdNodeId,
  input wire logic treeIdRoot,
  input wire logic treeIdArbTimeout,
  input wire logic stateTimeout,
  input wire logic configGapLoad,
  input wire logic [5:0] configGapValue,
  input wire logic [NUM_PORTS-1:0] portStatusChange,
  input wire logic [NUM_PORTS-1:0] resumeStart,
  output logic busResetActive,
  output logic busResetLong,
  output logic nodeIdValid,
  output logic rootHoldoff,
  output logic [5:0] gapCount,
  output logic selfIdLinkActive,
  output logic selfIdContender,
  output logic [2:0] selfIdPowerClass,
  output logic fastArbEnable,
  output logic mixedSpeedEnable,
  output logic linkIfEnable,
  output logic linkActivate,
  output logic portChangeNotify
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [5:0] nodeId_reg;
  logic nodeIdValid_reg;
  logic root_reg;
  logic holdoff_reg;
  logic longReq_reg;
  logic shortReq_reg;
  logic [5:0] gap_reg;
  logic resetSinceWrite_reg;
  logic link_active_control_reg;
  logic contender_reg;
  logic [2:0] pwrClass_reg;
  logic strapDone_reg;
  logic watchdog_reg;
  logic accel_reg;
  logic multi_reg;
  logic [2:0] page_reg;
  logic [3:0] port_reg;
  logic [NUM_PORTS-1:0] intEn_reg;
  logic cpsPrev_reg;
  logic linkAct_reg;
  logic linkIf_reg;
  logic wake_reg;
  logic notify_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [3:0] idx;
  logic mapped;
  logic wrEn;
  logic wrReset;
  logic wrSelfId;
  logic wrEvent;
  logic wrSelect;
  logic wrPortCtrl;
  logic portValid;
  logic gapLoad;
  logic busResetEvent;
  logic resetBegin;
  logic portEventSet;
  logic [NUM_FLAGS-1:0] flagSet;
  logic [NUM_FLAGS-1:0] flagClear;
  logic [NUM_FLAGS-1:0] flagVec;
  logic [7:0] readByte;

  // ************************************************************
  // Wishbone slave
  // ************************************************************
  assign idx = adr_i[5:2];
  assign mapped = (adr_i[7:6] == 2'h0);
  assign portValid = (port_reg < 4'(NUM_PORTS));

  // Writes land on the edge where the master sees ack
  assign wrEn = cyc_i & stb_i & we_i & ack_reg & sel_i[0] & mapped;
  assign wrReset = wrEn & (idx == IDX_RESET);
  assign wrSelfId = wrEn & (idx == IDX_SELFID);
  assign wrEvent = wrEn & (idx == IDX_EVENT);
  assign wrSelect = wrEn & (idx == IDX_SELECT);
  assign wrPortCtrl = wrEn & (idx == IDX_PORT_CTRL) &
    (page_reg == PAGE_PORT) & portValid;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= cyc_i & stb_i & ~ack_reg;
    end
  end

  // Read mux; unmapped words and reserved fields give zero
  always_comb begin
    readByte = 8'h00;
    unique case (idx)
      IDX_NODE: readByte = {nodeId_reg, root_reg, cablePowerIn};
      IDX_RESET: readByte = {holdoff_reg, longReq_reg, gap_reg};
      IDX_PORTCAP: readByte = {EXT_CODE, 1'b0, TOTAL_PORTS};
      IDX_SPEED: readByte = {MAX_SPEED, 1'b0, DELAY_CODE};
      IDX_SELFID: readByte = {link_active_control_reg, contender_reg, JITTER_CODE,
        pwrClass_reg};
      IDX_EVENT: readByte = {watchdog_reg, shortReq_reg, flagVec,
        accel_reg, multi_reg};
      IDX_SELECT: readByte = {page_reg, 1'b0, port_reg};
      IDX_PORT_CTRL: begin
        if (page_reg == PAGE_PORT && portValid) begin
          readByte[B_INTEN] = intEn_reg[port_reg[0]];
        end
      end
      default: readByte = 8'h00;
    endcase
    if (!mapped) begin
      readByte = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !ack_reg) begin
      rdata_reg <= {24'h00_0000, readByte};
    end
  end

  assign dat_o = rdata_reg;
  assign ack_o = ack_reg;

  // ************************************************************
  // Bus reset
  // ************************************************************
  spr_reset_timer uResetTimer (
    .clk(clk),
    .nrst(nrst),
    .reqLong(longReq_reg),
    .reqShort(shortReq_reg),
    .stateTimeout(stateTimeout),
    .phyBusy(phyBusy),
    .resetBegin(resetBegin),
    .resetActive(busResetActive),
    .resetLong(busResetLong)
  );

  assign busResetEvent = resetBegin | peerBusReset;

  // Requests drop when any bus reset begins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      longReq_reg <= 1'b0;
      shortReq_reg <= 1'b0;
    end else begin
      if (busResetEvent) begin
        longReq_reg <= 1'b0;
        shortReq_reg <= 1'b0;
      end else begin
        if (wrReset) begin
          longReq_reg <= dat_i[B_LONGREQ];
        end
        if (wrEvent) begin
          shortReq_reg <= dat_i[B_SHORTREQ];
        end
      end
    end
  end

  // ************************************************************
  // Node identity and root
  // ************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nodeId_reg <= 6'h00;
      nodeIdValid_reg <= 1'b0;
    end else if (busResetEvent) begin
      nodeIdValid_reg <= 1'b0;
    end else if (selfIdDone) begin
      nodeId_reg <= selfIdNodeId;
      nodeIdValid_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      root_reg <= 1'b0;
    end else if (busResetEvent) begin
      root_reg <= 1'b0;
    end else if (treeIdRoot) begin
      root_reg <= 1'b1;
    end
  end

  // ************************************************************
  // Gap count
  // ************************************************************
  assign gapLoad = wrReset | configGapLoad;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_reg <= GAP_RESET;
      resetSinceWrite_reg <= 1'b0;
    end else if (gapLoad) begin
      gap_reg <= wrReset ? dat_i[5:0] : configGapValue;
      resetSinceWrite_reg <= 1'b0;
    end else if (busResetEvent) begin
      if (resetSinceWrite_reg) begin
        gap_reg <= GAP_RESET;
      end
      resetSinceWrite_reg <= 1'b1;
    end
  end

  // ************************************************************
  // Control bits kept across bus reset
  // ************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      holdoff_reg <= 1'b0;
    end else if (wrReset) begin
      holdoff_reg <= dat_i[B_HOLDOFF];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link_active_control_reg <= LINK_ACTIVE_CONTROL_RESET;
      contender_reg <= 1'b0;
    end else if (wrSelfId) begin
      link_active_control_reg <= dat_i[B_LINK_ACTIVE_CONTROL];
      contender_reg <= dat_i[B_CONTEND];
    end
  end

  // Straps are caught on the first edge after reset release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwrClass_reg <= 3'h0;
      strapDone_reg <= 1'b0;
    end else if (!strapDone_reg) begin
      pwrClass_reg <= powerCategoryStraps;
      strapDone_reg <= 1'b1;
    end else if (wrSelfId) begin
      pwrClass_reg <= dat_i[2:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watchdog_reg <= 1'b0;
      accel_reg <= 1'b0;
      multi_reg <= 1'b0;
    end else if (wrEvent) begin
      watchdog_reg <= dat_i[B_WDOG];
      accel_reg <= dat_i[B_ACCEL];
      multi_reg <= dat_i[B_MULTI];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      page_reg <= PAGE_RESET;
      port_reg <= PORT_RESET;
    end else if (wrSelect) begin
      page_reg <= dat_i[7:5];
      port_reg <= dat_i[3:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      intEn_reg <= '0;
    end else if (wrPortCtrl) begin
      intEn_reg[port_reg[0]] <= dat_i[B_INTEN];
    end
  end

  // ************************************************************
  // Event flags
  // ************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpsPrev_reg <= 1'b0;
    end else begin
      cpsPrev_reg <= cablePowerIn;
    end
  end

  assign portEventSet = (|(portStatusChange & intEn_reg)) |
    (watchdog_reg & (|resumeStart));

  always_comb begin
    flagSet = '0;
    flagSet[FLG_PEVT] = portEventSet;
    flagSet[FLG_TOUT] = stateTimeout;
    flagSet[FLG_PFAIL] = cpsPrev_reg & ~cablePowerIn;
    flagSet[FLG_LOOP] = treeIdArbTimeout;
  end

  // Only ones written clear; zeros leave a flag alone
  assign flagClear = {NUM_FLAGS{wrEvent}} &
    dat_i[B_FLAG_LO +: NUM_FLAGS];

  spr_flag_if flagBus[NUM_FLAGS] ();

  for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
    assign flagBus[i].set = flagSet[i];
    assign flagBus[i].clear = flagClear[i];
    assign flagVec[i] = flagBus[i].flag;
    spr_event_flag uFlag (
      .clk(clk),
      .nrst(nrst),
      .fl(flagBus[i].owner)
    );
  end

  // ************************************************************
  // Link side
  // ************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      linkAct_reg <= 1'b0;
      linkIf_reg <= 1'b0;
      wake_reg <= 1'b0;
      notify_reg <= 1'b0;
    end else begin
      linkAct_reg <= link_active_control_reg & linkPowerStatus;
      linkIf_reg <= linkPowerStatus;
      wake_reg <= flagVec[FLG_LOOP] & watchdog_reg &
        ~linkPowerStatus;
      notify_reg <= portEventSet;
    end
  end

  assign nodeIdValid = nodeIdValid_reg;
  assign rootHoldoff = holdoff_reg;
  assign gapCount = gap_reg;
  assign selfIdLinkActive = linkAct_reg;
  assign selfIdContender = contender_reg;
  assign selfIdPowerClass = pwrClass_reg;
  assign fastArbEnable = accel_reg;
  assign mixedSpeedEnable = multi_reg;
  assign linkIfEnable = linkIf_reg;
  assign linkActivate = wake_reg;
  assign portChangeNotify = notify_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_ack_single: assert property ((cyc_i && stb_i && !ack_o) |=>
    ack_o ##1 !ack_o) else $error("ack not one cycle");
  a_rsvd_zero: assert property (ack_o && (!mapped ||
    idx == IDX_RSVD6) |-> dat_o == 32'h0000_0000)
    else $error("reserved read nonzero");
  a_reset_clears: assert property (busResetEvent |=> !longReq_reg &&
    !shortReq_reg && !root_reg && !nodeIdValid_reg)
    else $error("bus reset left state");
  a_gap_reload: assert property (busResetEvent && resetSinceWrite_reg &&
    !gapLoad |=> gap_reg == GAP_RESET)
    else $error("gap not reloaded");
  a_link_and: assert property (link_active_control_reg && linkPowerStatus &&
    !wrSelfId ##1 linkPowerStatus |=> selfIdLinkActive)
    else $error("link bit wrong");
  a_cps_drop: assert property ($fell(cablePowerIn) |=>
    flagVec[FLG_PFAIL]) else $error("power drop missed");
  a_link_wake: assert property (flagVec[FLG_LOOP] && watchdog_reg &&
    !linkPowerStatus |=> linkActivate)
    else $error("link not woken");
  a_port_event: assert property ((|(portStatusChange & intEn_reg)) |=>
    flagVec[FLG_PEVT] && portChangeNotify)
    else $error("port event lost");
  a_page_hold: assert property (!wrSelect && busResetEvent |=>
    $stable(page_reg) && $stable(port_reg))
    else $error("selector changed");

endmodule // spr_phy_regs

// ---- spr_link_model.sv ----
// Link layer controller model that wakes when asked
`timescale 1ns/1ps
module spr_link_model #(
  parameter int WAKE_DLY = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic linkActivate,
  output logic linkPowerStatus
);
  int cnt;
  // Power comes up some cycles after the wake request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      linkPowerStatus <= 1'b0;
      cnt <= 0;
    end else if (linkActivate && !linkPowerStatus) begin
      cnt <= cnt + 1;
      if (cnt >= WAKE_DLY) linkPowerStatus <= 1'b1;
    end
  end
endmodule // spr_link_model

// ---- tb_serial_bus_phy_register_space.sv ----
// Self-checking testbench of the PHY register space
`timescale 1ns/1ps
module tb_serial_bus_phy_register_space
  import spr_pkg::*;
;
  logic clk, nrst, cyc_i, stb_i, we_i, cablePowerIn, phyBusy, peerBusReset;
  logic selfIdDone, treeIdRoot, treeIdArbTimeout, stateTimeout;
  logic configGapLoad;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i;
  logic [2:0] powerCategoryStraps;
  logic [5:0] selfIdNodeId, configGapValue, rv;
  logic [1:0] portStatusChange, resumeStart;
  wire logic [31:0] dat_o;
  wire logic [5:0] gapCount;
  wire logic ack_o, linkPowerStatus, linkActivate, busResetActive;
  wire logic nodeIdValid;
  wire logic busResetLong, rootHoldoff, selfIdLinkActive, selfIdContender;
  wire logic fastArbEnable, mixedSpeedEnable, linkIfEnable;
  wire logic [2:0] selfIdPowerClass;
  int failCount, nCompared, seed, n;
  logic [31:0] expQ[$];
  logic [7:0] ra[7] = '{8'h04, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h1c, 8'h40};
  logic [7:0] re[7] = '{8'h3f, 8'he2, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};

  spr_phy_regs spr_phy_regs_i (.clk, .nrst, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .cablePowerIn, .linkPowerStatus,
    .powerCategoryStraps, .phyBusy, .peerBusReset, .selfIdDone,
    .selfIdNodeId, .treeIdRoot, .treeIdArbTimeout, .stateTimeout,
    .configGapLoad, .configGapValue, .portStatusChange, .resumeStart,
    .busResetActive, .busResetLong, .nodeIdValid, .rootHoldoff,
    .gapCount, .selfIdLinkActive, .selfIdContender,
    .selfIdPowerClass, .fastArbEnable, .mixedSpeedEnable,
    .linkIfEnable, .linkActivate, .portChangeNotify());
  spr_link_model spr_link_model_i (.clk, .nrst, .linkActivate,
    .linkPowerStatus);

  // ************************************************************
  // Bus cycles and comparisons
  // ************************************************************
  task automatic stop_test();
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    nCompared++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] %0t level %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      failCount++;
      stop_test();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back({24'h0, e});
    wb(1'b0, a, 8'h00);
  endtask

  task automatic pulse(input int k);
    case (k)
      0: portStatusChange <= 2'b01;
      1: stateTimeout <= 1'b1;
      2: cablePowerIn <= 1'b0;
      3: treeIdArbTimeout <= 1'b1;
      4: peerBusReset <= 1'b1;
      default: selfIdDone <= 1'b1;
    endcase
    @(posedge clk);
    {portStatusChange, stateTimeout, treeIdArbTimeout} <= '0;
    {peerBusReset, selfIdDone, treeIdRoot, configGapLoad} <= '0;
    cablePowerIn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic waitReset(input logic lvl);
    n = 0;
    while (busResetActive !== lvl && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) begin
      failCount++;
      stop_test();
    end
  endtask

  always @(posedge clk)
    if (cyc_i && stb_i && !we_i && ack_o === 1'b1) chk(dat_o, expQ.pop_front());

  // ************************************************************
  // Clock, reset and scenarios
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    seed = 32'ha8ab;
    {nrst, cyc_i, stb_i, we_i, phyBusy, peerBusReset, selfIdDone} = '0;
    {treeIdRoot, treeIdArbTimeout, stateTimeout, configGapLoad} = '0;
    {adr_i, dat_i, portStatusChange, resumeStart} = '0;
    sel_i = 4'hf;
    cablePowerIn = 1'b1;
    powerCategoryStraps = 3'($random(seed));
    selfIdNodeId = 6'($random(seed));
    configGapValue = 6'($random(seed));
    failCount = 0;
    nCompared = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) rd(ra[i], re[i]);
    rd(8'h10, {5'h10, powerCategoryStraps});
    rd(8'h00, 8'h01);
    $display("reset values done");
    wb(1'b1, 8'h1c, 8'h61);
    rd(8'h1c, 8'h61);
    rd(8'h24, 8'h00);
    wb(1'b1, 8'h1c, 8'h00);
    wb(1'b1, 8'h24, 8'h10);
    rd(8'h24, 8'h10);
    wb(1'b1, 8'h14, 8'h80);
    for (int k = 0; k < 4; k++) begin
      pulse(k);
      if (k == 3) chkBit(linkActivate, 1'b1);
      rd(8'h14, 8'h80 | (8'h04 << k));
      wb(1'b1, 8'h14, 8'h80);
      rd(8'h14, 8'h80 | (8'h04 << k));
      wb(1'b1, 8'h14, 8'h80 | (8'h04 << k));
      rd(8'h14, 8'h80);
    end
    $display("event flags done");
    waitReset(1'b0);
    wb(1'b1, 8'h14, 8'hc0);
    waitReset(1'b1);
    waitReset(1'b0);
    chk(n, 26);
    rd(8'h14, 8'h80);
    $display("short reset done");
    rv = 6'($random(seed));
    wb(1'b1, 8'h04, {2'b10, rv});
    rd(8'h04, {2'b10, rv});
    treeIdRoot <= 1'b1;
    pulse(5);
    chkBit(nodeIdValid, 1'b1);
    rd(8'h00, {selfIdNodeId, 2'b11});
    pulse(4);
    chkBit(nodeIdValid, 1'b0);
    pulse(4);
    rd(8'h04, 8'hbf);
    chkBit(rootHoldoff, 1'b1);
    configGapLoad <= 1'b1;
    pulse(6);
    chk(gapCount, configGapValue);
    $display("gap and identity done");
    chkBit(selfIdLinkActive, 1'b1);
    chkBit(linkIfEnable, 1'b1);
    wb(1'b1, 8'h10, 8'h45);
    repeat (2) @(posedge clk);
    chkBit(selfIdLinkActive, 1'b0);
    chkBit(selfIdContender, 1'b1);
    chk(selfIdPowerClass, 3'h5);
    wb(1'b1, 8'h14, 8'h83);
    rd(8'h14, 8'h83);
    chk({fastArbEnable, mixedSpeedEnable}, 2'b11);
    $display("self-ID fields done");
    phyBusy <= 1'b1;
    wb(1'b1, 8'h04, 8'h40);
    repeat (3) @(posedge clk);
    chkBit(busResetActive, 1'b0);
    phyBusy <= 1'b0;
    waitReset(1'b1);
    chkBit(busResetLong, 1'b1);
    rd(8'h04, 8'h00);
    $display("long reset done");
    stop_test();
  end
endmodule // tb_serial_bus_phy_register_space
